// ==== rtl/afs_pkg.sv ====
// Package with constants and carriers for the fault status and hold block.
package afs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int RST_QUAL_US = 512;
  localparam int HIZ_US = 800;
  localparam int STAB_MS = 3;
  localparam int SAMPLE_US = 16;
  localparam int RST_QUAL_CYC = RST_QUAL_US * CLK_MHZ;
  localparam int HIZ_CYC = HIZ_US * CLK_MHZ;
  localparam int STAB_CYC = STAB_MS * 1000 * CLK_MHZ;
  localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
  localparam int FILT_CORNER_HZ = 400;
  localparam int FILT_POLES = 4;

  // ----------------------------------------------------------------
  // Widths and carriers
  // ----------------------------------------------------------------
  localparam int DW = 12;
  localparam int CW = 24;
  localparam int FILT_SHIFT = 3;
  localparam logic [CW-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CW-1:0] CNT_ONE = 24'h000001;
  localparam logic [DW-1:0] ST_STIM = 12'h040;
  localparam logic [DW-1:0] DATA_ZERO = 12'h000;

  typedef enum logic [1:0] {
    AFS_HIZ = 2'b00,
    AFS_STAB = 2'b01,
    AFS_RUN = 2'b10
  } afs_phase_t;

  typedef struct packed {
    logic parity;
    logic over_temp;
    logic clk_freq;
    logic terminal;
  } afs_fault_t;

  typedef struct packed {
    logic [DW-1:0] x;
    logic [DW-1:0] y;
  } afs_axes_t;

endpackage

// ==== rtl/afs_core.sv ====
// Pin control logic: reset detect, status latch, self-test and hold.
// What this block does
// (R1) Reset low with serial clock high for 512 us asserts internal reset.
// (R2) Status goes high on parity, temperature, clock fault, reset or init.
// (R3) After any reset status floats for about 800 us.
// (R4) Then status drives high and a 3 ms stabilization delay starts.
// (R5) During stabilization clear requests are ignored, status stays high.
// (R6) Status stays high until a self-test rising edge clears the latch.
// (R7) A fault still present at clear sets the latch again at once.
// (R8) Terminal faults set the latch again after every clear.
// (R9) Self-test stimulus is active while the synchronized self-test pin is high, two cycles after the pin.
// (R10) Self-test moves both axes positive, or negative when polarity set.
// (R11) With hold low, held outputs follow every new filter sample.
// (R12) A hold rising edge freezes outputs; no update while hold high.
// (R13) Filter makes a sample every 16 us, four-pole 400 Hz low-pass.
// (R14) Normal mode keeps the serial interface off; pins are dedicated.
// (R15) Reset pin has a pull-up so an open pin never resets.
// (R16) All control inputs are synchronized before edge or level timing.
// (R17) Reset qualification restarts whenever either level is lost early.
`timescale 1ns/10ps

module afs_core #(
  parameter int RST_QUAL_CYC = afs_pkg::RST_QUAL_CYC,
  parameter int HIZ_CYC = afs_pkg::HIZ_CYC,
  parameter int STAB_CYC = afs_pkg::STAB_CYC,
  parameter int SAMPLE_CYC = afs_pkg::SAMPLE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic reset_pin_b_i,
  input wire logic reset_pin_oe_i,
  input wire logic serial_clk_i,
  input wire logic self_test_pin_i,
  input wire logic capture_hold_input_i,
  input wire logic self_test_polarity_bit_i,
  input wire afs_pkg::afs_fault_t fault_i,
  input wire afs_pkg::afs_axes_t accel_i,
  output logic status_o,
  output logic status_oe_o,
  output logic self_test_active_o,
  output logic spi_enable_o,
  output logic internal_reset_o,
  output logic sample_valid_o,
  output afs_pkg::afs_axes_t axis_out_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] rst_s;
    logic [2:0] clk_s;
    logic [2:0] st_s;
    logic [2:0] hold_s;
    logic [afs_pkg::CW-1:0] qual;
    logic int_rst;
    afs_pkg::afs_phase_t phase;
    logic [afs_pkg::CW-1:0] tmr;
    logic latch;
    logic [afs_pkg::CW-1:0] smp;
    logic smp_v;
    logic [3:0][afs_pkg::DW-1:0] fx;
    logic [3:0][afs_pkg::DW-1:0] fy;
    afs_pkg::afs_axes_t held;
  } afs_state_t;

  afs_state_t s_q;
  afs_state_t s_d;
  logic rst_lvl;
  logic clk_lvl;
  logic st_rise;
  logic hold_rise;
  logic fault_any;
  logic [afs_pkg::DW-1:0] in_x;
  logic [afs_pkg::DW-1:0] in_y;

  function automatic logic [afs_pkg::DW-1:0] afs_pole(
    input logic [afs_pkg::DW-1:0] acc,
    input logic [afs_pkg::DW-1:0] in_v
  );
    logic signed [afs_pkg::DW:0] diff;
    diff = $signed({1'b0, in_v}) - $signed({1'b0, acc});
    afs_pole = acc + afs_pkg::DW'(diff >>> afs_pkg::FILT_SHIFT);
  endfunction

  function automatic logic [afs_pkg::DW-1:0] afs_stim(
    input logic [afs_pkg::DW-1:0] v,
    input logic on,
    input logic neg
  );
    if (!on) begin
      afs_stim = v;
    end else if (neg) begin
      afs_stim = v - afs_pkg::ST_STIM;
    end else begin
      afs_stim = v + afs_pkg::ST_STIM;
    end
  endfunction

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  // The pull-up is modelled here: an undriven reset pin reads high.
  assign rst_lvl = !reset_pin_oe_i || reset_pin_b_i; // R15
  assign clk_lvl = serial_clk_i;
  assign st_rise = s_q.st_s[1] && !s_q.st_s[2]; // R16
  assign hold_rise = s_q.hold_s[1] && !s_q.hold_s[2]; // R16
  assign fault_any = fault_i.parity || fault_i.over_temp ||
                     fault_i.clk_freq || fault_i.terminal;
  assign in_x = afs_stim(accel_i.x, s_q.st_s[1], self_test_polarity_bit_i);
  assign in_y = afs_stim(accel_i.y, s_q.st_s[1], self_test_polarity_bit_i);

  always_comb begin
    s_d = s_q;
    s_d.rst_s = {s_q.rst_s[1:0], rst_lvl}; // R16
    s_d.clk_s = {s_q.clk_s[1:0], clk_lvl}; // R16
    s_d.st_s = {s_q.st_s[1:0], self_test_pin_i}; // R16
    s_d.hold_s = {s_q.hold_s[1:0], capture_hold_input_i}; // R16
    s_d.int_rst = 1'b0;
    s_d.smp_v = 1'b0;

    // ----------------------------------------------------------------
    // Pin reset qualification
    // ----------------------------------------------------------------
    if (!s_q.rst_s[1] && s_q.clk_s[1]) begin
      if (s_q.qual == afs_pkg::CW'(RST_QUAL_CYC - 1)) begin
        s_d.int_rst = 1'b1; // R1
        s_d.qual = afs_pkg::CNT_ZERO;
      end else begin
        s_d.qual = s_q.qual + afs_pkg::CNT_ONE;
      end
    end else begin
      s_d.qual = afs_pkg::CNT_ZERO; // R17
    end

    // ----------------------------------------------------------------
    // Status sequencing and latch
    // ----------------------------------------------------------------
    case (s_q.phase)
      afs_pkg::AFS_HIZ: begin
        s_d.latch = 1'b1; // R2
        if (s_q.tmr == afs_pkg::CW'(HIZ_CYC - 1)) begin
          s_d.phase = afs_pkg::AFS_STAB; // R4
          s_d.tmr = afs_pkg::CNT_ZERO;
        end else begin
          s_d.tmr = s_q.tmr + afs_pkg::CNT_ONE; // R3
        end
      end
      afs_pkg::AFS_STAB: begin
        s_d.latch = 1'b1; // R5
        if (s_q.tmr == afs_pkg::CW'(STAB_CYC - 1)) begin
          s_d.phase = afs_pkg::AFS_RUN;
          s_d.tmr = afs_pkg::CNT_ZERO;
        end else begin
          s_d.tmr = s_q.tmr + afs_pkg::CNT_ONE; // R4
        end
      end
      afs_pkg::AFS_RUN: begin
        // Set wins over clear so a live fault is never lost.
        if (fault_any) begin
          s_d.latch = 1'b1; // R7 R8
        end else if (st_rise) begin
          s_d.latch = 1'b0; // R6
        end
      end
      default: begin
        s_d.phase = afs_pkg::AFS_HIZ;
        s_d.tmr = afs_pkg::CNT_ZERO;
      end
    endcase

    // ----------------------------------------------------------------
    // Sample tick, filter and hold
    // ----------------------------------------------------------------
    if (s_q.smp == afs_pkg::CW'(SAMPLE_CYC - 1)) begin
      s_d.smp = afs_pkg::CNT_ZERO;
      s_d.smp_v = 1'b1; // R13
      s_d.fx[0] = afs_pole(s_q.fx[0], in_x); // R10
      s_d.fy[0] = afs_pole(s_q.fy[0], in_y); // R10
      for (int i = 1; i < afs_pkg::FILT_POLES; i++) begin
        s_d.fx[i] = afs_pole(s_q.fx[i], s_q.fx[i-1]); // R13
        s_d.fy[i] = afs_pole(s_q.fy[i], s_q.fy[i-1]); // R13
      end
    end else begin
      s_d.smp = s_q.smp + afs_pkg::CNT_ONE;
    end
    // The hold edge is also checked so the first held cycle never updates.
    if (s_q.smp_v && !s_q.hold_s[1] && !hold_rise) begin
      s_d.held.x = s_q.fx[afs_pkg::FILT_POLES-1]; // R11
      s_d.held.y = s_q.fy[afs_pkg::FILT_POLES-1]; // R11
    end

    // A qualified pin reset restarts the status sequence.
    if (s_q.int_rst) begin
      s_d.phase = afs_pkg::AFS_HIZ; // R3
      s_d.tmr = afs_pkg::CNT_ZERO;
      s_d.latch = 1'b1; // R2
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
      s_q.rst_s <= 3'h7;
      s_q.latch <= 1'b1;
      s_q.phase <= afs_pkg::AFS_HIZ;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign status_o = s_q.latch; // R2
  assign status_oe_o = (s_q.phase != afs_pkg::AFS_HIZ); // R3
  assign self_test_active_o = s_q.st_s[1]; // R9
  assign spi_enable_o = 1'b0; // R14
  assign internal_reset_o = s_q.int_rst;
  assign sample_valid_o = s_q.smp_v;
  assign axis_out_o = s_q.held; // R12

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_reset_taken;
    s_q.int_rst;
  endsequence

  sequence seq_hiz_then_drive;
    !status_oe_o ##1 status_oe_o;
  endsequence

  sequence seq_sample_free;
    s_q.smp_v && !s_q.hold_s[1];
  endsequence

  AST_RESET_QUAL: assert property ( // R1
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    $rose(s_d.int_rst) |-> (s_q.qual == afs_pkg::CW'(RST_QUAL_CYC - 1)))
    else $error("internal reset without full qualification");

  AST_QUAL_RESTART: assert property ( // R17
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (s_q.rst_s[1] || !s_q.clk_s[1]) |=> (s_q.qual == afs_pkg::CNT_ZERO))
    else $error("qualification count not restarted");

  AST_HIZ_AFTER_RST: assert property ( // R3
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    seq_reset_taken |=> !status_oe_o && status_o)
    else $error("status not floated after reset");

  AST_HIZ_MIN: assert property ( // R3
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    seq_reset_taken |=> (!status_oe_o) [*8])
    else $error("status driven too soon after reset");

  AST_DRIVE_HIGH: assert property ( // R4
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    seq_hiz_then_drive |-> status_o && s_q.phase == afs_pkg::AFS_STAB)
    else $error("status not driven high after float");

  AST_STAB_HOLD: assert property ( // R5
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (s_q.phase == afs_pkg::AFS_STAB && !s_q.int_rst) |=> status_o)
    else $error("status cleared during stabilization");

  AST_CLEAR: assert property ( // R6
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (s_q.phase == afs_pkg::AFS_RUN && st_rise && !fault_any && !s_q.int_rst)
    |=> !status_o)
    else $error("self-test edge did not clear status");

  AST_FAULT_SET: assert property ( // R7
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    fault_any |=> status_o)
    else $error("fault did not set status");

  AST_STICKY: assert property ( // R6
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (status_o && !st_rise && !$past(s_q.int_rst)) |=> status_o)
    else $error("status dropped without clear");

  // The two-cycle lag is the synchronizer depth on the self-test pin.
  AST_SELF_TEST: assert property ( // R9
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    ($past(rst_b_i) && $past(rst_b_i, 2)) |->
    (self_test_active_o == $past(self_test_pin_i, 2)))
    else $error("stimulus does not follow the self-test pin");

  AST_HOLD_FROZEN: assert property ( // R12
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (s_q.hold_s[1] && s_q.hold_s[2]) [*2] |-> $stable(axis_out_o))
    else $error("held output changed");

  AST_HOLD_FOLLOW: assert property ( // R11
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    seq_sample_free |=>
    (axis_out_o.x == $past(s_q.fx[afs_pkg::FILT_POLES-1])) &&
    (axis_out_o.y == $past(s_q.fy[afs_pkg::FILT_POLES-1])))
    else $error("held output missed a sample");

  AST_SAMPLE_RATE: assert property ( // R13
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    s_q.smp_v |=> (!s_q.smp_v) [*8])
    else $error("samples too close together");

endmodule

// ==== dv/afs_host_model.sv ====
// Host side model that drives the reset, serial clock, self-test and hold pins.
`timescale 1ns/10ps

module afs_host_model (
  input wire logic sys_clk_i,
  output logic reset_pin_b_o,
  output logic reset_pin_oe_o,
  output logic serial_clk_o,
  output logic self_test_pin_o,
  output logic capture_hold_o
);
  // A released reset pin shows the pull-up level, never a stale low.
  initial begin
    reset_pin_b_o = 1'b1;
    reset_pin_oe_o = 1'b0;
    serial_clk_o = 1'b0;
    self_test_pin_o = 1'b0;
    capture_hold_o = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // Overlap of reset low and serial clock high for n cycles.
  task automatic pin_reset(input int n, input logic drive);
    step(1);
    // The data level is low either way, so only the enable may reset.
    reset_pin_oe_o = drive;
    reset_pin_b_o = 1'b0;
    serial_clk_o = 1'b1;
    step(n);
    reset_pin_oe_o = 1'b0;
    reset_pin_b_o = 1'b1;
    serial_clk_o = 1'b0;
  endtask

  task automatic st_set(input logic v);
    step(1);
    self_test_pin_o = v;
  endtask

  task automatic set_hold(input logic v);
    step(1);
    capture_hold_o = v;
  endtask
endmodule

// ==== dv/accel_fault_status_and_hold_control_tb_top.sv ====
// Self-checking testbench for the fault status and hold block.
`timescale 1ns/10ps

module accel_fault_status_and_hold_control_tb_top;
  localparam int RQ = 16;
  localparam int HZ = 20;
  localparam int SB = 40;
  localparam int SP = 10;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  wire logic rst_pin_b;
  wire logic rst_pin_oe;
  wire logic sclk;
  wire logic st_pin;
  wire logic hold;
  logic pol;
  afs_pkg::afs_fault_t fault;
  afs_pkg::afs_axes_t accel;
  afs_pkg::afs_axes_t axes, base;
  logic status, status_oe, act, spi, irst, valid;
  int bad_count = 0;
  int checks_done = 0;
  int rst_seen = 0;

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (irst === 1'b1) rst_seen++;

  afs_host_model i_host (
    .sys_clk_i(sys_clk),
    .reset_pin_b_o(rst_pin_b),
    .reset_pin_oe_o(rst_pin_oe),
    .serial_clk_o(sclk),
    .self_test_pin_o(st_pin),
    .capture_hold_o(hold)
  );

  afs_core #(
    .RST_QUAL_CYC(RQ),
    .HIZ_CYC(HZ),
    .STAB_CYC(SB),
    .SAMPLE_CYC(SP)
  ) i_dut (
    .sys_clk_i(sys_clk),
    .rst_b_i(rst_b),
    .reset_pin_b_i(rst_pin_b),
    .reset_pin_oe_i(rst_pin_oe),
    .serial_clk_i(sclk),
    .self_test_pin_i(st_pin),
    .capture_hold_input_i(hold),
    .self_test_polarity_bit_i(pol),
    .fault_i(fault),
    .accel_i(accel),
    .status_o(status),
    .status_oe_o(status_oe),
    .self_test_active_o(act),
    .spi_enable_o(spi),
    .internal_reset_o(irst),
    .sample_valid_o(valid),
    .axis_out_o(axes)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      bad_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask

  task automatic wait_up(input int lim, output int n);
    n = 0;
    while (!(status_oe === 1'b1 && status === 1'b1) && n < lim) begin
      step(1);
      n++;
    end
    chk(n < lim, "status never driven high");
  endtask

  task automatic wait_valid(input int lim, output int n);
    n = 0;
    do begin
      step(1);
      n++;
    end while (valid !== 1'b1 && n < lim);
  endtask

  task automatic test_done;
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_boot;
    int n;
    chk(status_oe === 1'b0, "status driven right after reset");
    wait_up(HZ + 10, n);
    chk(n >= HZ - 4, "status left high impedance early");
    i_host.st_set(1'b1);
    step(6);
    chk(status === 1'b1, "clear taken during stabilization");
    i_host.st_set(1'b0);
    step(SB);
  endtask

  task automatic t_clear;
    i_host.st_set(1'b1);
    step(6);
    chk(act === 1'b1, "stimulus off while pin high");
    chk(status === 1'b0, "status not cleared");
    chk(spi === 1'b0, "serial interface enabled");
    i_host.st_set(1'b0);
    step(4);
    chk(act === 1'b0, "stimulus on while pin low");
    chk(status === 1'b0, "status set without fault");
  endtask

  // Clearing while the fault holds must lose against the set.
  task automatic t_faults;
    for (int i = 0; i < 4; i++) begin
      fault = afs_pkg::afs_fault_t'(4'h8 >> i);
      step(5);
      chk(status === 1'b1, "fault not reported");
      i_host.st_set(1'b1);
      step(6);
      chk(status === 1'b1, "clear won over fault");
      i_host.st_set(1'b0);
      fault = '0;
      step(2);
      i_host.st_set(1'b1);
      step(6);
      chk(status === 1'b0, "clear failed after fault");
      i_host.st_set(1'b0);
      step(2);
    end
  endtask

  task automatic t_hold;
    int n;
    accel = '{x: 12'h400, y: 12'h400};
    wait_valid(SP + 3, n);
    wait_valid(SP + 3, n);
    chk(n == SP, "sample interval wrong");
    base = axes;
    // Four cascaded stages need several samples before the last one moves.
    step(8 * SP);
    chk(axes !== base, "outputs not following samples");
    i_host.set_hold(1'b1);
    step(3);
    base = axes;
    accel = '{x: 12'h800, y: 12'h800};
    step(5 * SP);
    chk(axes === base, "outputs moved while held");
    i_host.set_hold(1'b0);
    accel = '{x: 12'h400, y: 12'h400};
    step(200 * SP);
  endtask

  task automatic t_polarity;
    base = axes;
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      i_host.st_set(1'b1);
      step(200 * SP);
      if (p == 0) chk(axes.x > base.x && axes.y > base.y, "not positive");
      else chk(axes.x < base.x && axes.y < base.y, "not negative");
      i_host.st_set(1'b0);
      step(200 * SP);
    end
  endtask

  task automatic t_pin_reset;
    int n;
    i_host.pin_reset(RQ - 4, 1'b1);
    i_host.pin_reset(RQ - 4, 1'b1);
    step(RQ);
    chk(rst_seen == 0, "reset on broken overlap");
    i_host.pin_reset(RQ + 8, 1'b0);
    step(4);
    chk(rst_seen == 0, "reset from open pin");
    i_host.pin_reset(RQ + 6, 1'b1);
    step(4);
    chk(rst_seen == 1, "no single reset pulse");
    chk(status_oe === 1'b0, "status driven after pin reset");
    wait_up(HZ + 10, n);
  endtask

  initial begin
    pol = 1'b0;
    fault = '0;
    accel = '0;
    step(10);
    rst_b = 1'b1;
    t_boot();
    t_clear();
    t_faults();
    t_hold();
    t_polarity();
    t_pin_reset();
    test_done();
  end

  // Generous ceiling: the scenarios need roughly ten thousand cycles.
  initial begin
    #(40 * 30000);
    bad_count++;
    test_done();
  end
endmodule
